//--- rtl/dsp_top.sv
/*
 Dual serial port core: register port, baud selection, pin exchange, interrupt.
 Assumes timer overflow pulses come from logic on clk; pins come from outside.
*/
// The plain strobed port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module dsp_top
	import dsp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	input  wire logic       t1_ovf,
	input  wire logic       t3_ovf,
	input  wire logic       pin_p20_in,
	output logic            pin_p20_out,
	output logic            pin_p20_oe_n,
	input  wire logic       pin_p03_in,
	output logic            pin_p03_out,
	output logic            pin_p03_oe_n,
	input  wire logic       rxd1_in,
	output logic            rxd1_out,
	output logic            rxd1_oe_n,
	output logic            txd1_out,
	output logic            irq
);
	typedef struct packed {
		logic [2:0] meta;
		logic [2:0] sync;
		logic [7:0] ctl0;
		logic [7:0] ctl1;
		logic       fe0;
		logic       fe1;
		logic [7:0] pwr0;
		logic [7:0] aux;
		logic [7:0] t3c;
		logic [3:0] irq_st;
		logic [3:0] irq_mask;
		logic [7:0] rdata;
		logic       start0;
		logic       start1;
		logic [7:0] tx0;
		logic [7:0] tx1;
		logic       p20_out;
		logic       p20_oe_n;
		logic       p03_out;
		logic       p03_oe_n;
		logic       rxd1_out;
		logic       rxd1_oe_n;
		logic       txd1_out;
		logic       irq;
	} dsp_top_t;

	dsp_top_t s;
	dsp_top_t next_s;

	dsp_port_if u0();
	dsp_port_if u1();

	logic [5:0] div0;
	logic [5:0] div1;
	logic       inc0;
	logic       inc1;
	logic       clr0;
	logic       clr1;
	logic       swap;
	logic [3:0] irq_clr;
	logic [3:0] irq_set;

	assign swap = s.aux[BIT_PIN_SWAP];

	// port 0 rate source
	always_comb begin
		inc0 = 1'h1;
		case (u0.mode)
			MODE_SYNC: div0 = s.ctl0[CTL_SM2] ? HALF_M0_FAST : HALF_M0_SLOW;
			MODE_ASYNC2: div0 = s.pwr0[BIT_DOUBLE] ? HALF_M2_FAST : HALF_M2_SLOW;
			default: begin
				inc0 = s.t3c[BIT_BAUD_SEL] ? t3_ovf : t1_ovf;
				div0 = s.pwr0[BIT_DOUBLE] ? HALF_OVF_P0_DBL : HALF_OVF_P0;
			end
		endcase
	end

	// port 1 rate source
	always_comb begin
		inc1 = 1'h1;
		case (u1.mode)
			MODE_SYNC: div1 = s.ctl1[CTL_SM2] ? HALF_M0_FAST : HALF_M0_SLOW;
			MODE_ASYNC2: div1 = s.t3c[BIT_DOUBLE] ? HALF_M2_FAST : HALF_M2_SLOW;
			default: begin
				inc1 = t3_ovf;
				div1 = HALF_OVF_P1;
			end
		endcase
	end

	// release the divider on the cycle the engine starts, so the first half bit is full length
	assign clr0 = !(u0.busy || u0.start_tx || (u0.mode == MODE_SYNC && u0.ren && !u0.ri_flag && !u0.set_ri));
	assign clr1 = !(u1.busy || u1.start_tx || (u1.mode == MODE_SYNC && u1.ren && !u1.ri_flag && !u1.set_ri));

	dsp_baud u_baud0 (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.clr      (clr0),
		.inc      (inc0),
		.half_div (div0),
		.tick     (u0.half_tick)
	);

	dsp_baud u_baud1 (
		.clk      (clk),
		.rst_n    (rst_n),
		.ce       (ce),
		.clr      (clr1),
		.inc      (inc1),
		.half_div (div1),
		.tick     (u1.half_tick)
	);

	assign u0.mode = dsp_mode_t'(s.ctl0[7:6]);
	assign u0.sm2 = s.ctl0[CTL_SM2];
	assign u0.ren = s.ctl0[CTL_REN];
	assign u0.ri_flag = s.ctl0[CTL_RI];
	assign u0.tb8 = s.ctl0[CTL_TB8];
	assign u0.start_tx = s.start0;
	assign u0.tx_byte = s.tx0;
	assign u0.data_in = swap ? s.sync[1] : s.sync[0];

	assign u1.mode = dsp_mode_t'(s.ctl1[7:6]);
	assign u1.sm2 = s.ctl1[CTL_SM2];
	assign u1.ren = s.ctl1[CTL_REN];
	assign u1.ri_flag = s.ctl1[CTL_RI];
	assign u1.tb8 = s.ctl1[CTL_TB8];
	assign u1.start_tx = s.start1;
	assign u1.tx_byte = s.tx1;
	assign u1.data_in = s.sync[2];

	dsp_port u_port0 (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.p     (u0.eng)
	);

	dsp_port u_port1 (
		.clk   (clk),
		.rst_n (rst_n),
		.ce    (ce),
		.p     (u1.eng)
	);

	assign irq_set = {u1.set_ri, u1.set_ti, u0.set_ri, u0.set_ti};
	assign irq_clr = (wr && addr == ADDR_IRQ_STATUS) ? wdata[3:0] : 4'h0;

	always_comb begin
		next_s = s;
		next_s.meta = {rxd1_in, pin_p03_in, pin_p20_in};
		next_s.sync = s.meta;
		next_s.start0 = 1'h0;
		next_s.start1 = 1'h0;
		next_s.rdata = RST_BYTE;

		if (wr) begin
			case (addr)
				ADDR_PORT0_DATA: begin
					next_s.tx0 = wdata;
					next_s.start0 = 1'h1;
				end
				ADDR_PORT1_DATA: begin
					next_s.tx1 = wdata;
					next_s.start1 = 1'h1;
				end
				ADDR_PORT0_CTL: begin
					next_s.ctl0[6:0] = wdata[6:0];
					if (s.pwr0[BIT_VIEW]) begin
						next_s.fe0 = wdata[7];
					end else begin
						next_s.ctl0[7] = wdata[7];
					end
				end
				ADDR_PORT1_CTL: begin
					next_s.ctl1[6:0] = wdata[6:0];
					if (s.t3c[BIT_VIEW]) begin
						next_s.fe1 = wdata[7];
					end else begin
						next_s.ctl1[7] = wdata[7];
					end
				end
				ADDR_PORT0_POWER: next_s.pwr0 = wdata;
				ADDR_AUX_ONE: next_s.aux = wdata & AUX_RO_MASK;
				ADDR_TIMER3_CTL: next_s.t3c = wdata;
				ADDR_IRQ_MASK: next_s.irq_mask = wdata[3:0];
				default: begin
				end
			endcase
		end

		// hardware set beats a same-cycle software clear
		if (u0.set_ti) next_s.ctl0[CTL_TI] = 1'h1;
		if (u0.set_ri) next_s.ctl0[CTL_RI] = 1'h1;
		if (u1.set_ti) next_s.ctl1[CTL_TI] = 1'h1;
		if (u1.set_ri) next_s.ctl1[CTL_RI] = 1'h1;
		next_s.irq_st = (s.irq_st & ~irq_clr) | irq_set;
		next_s.irq = |(next_s.irq_st & next_s.irq_mask);

		if (rd) begin
			case (addr)
				ADDR_PORT0_DATA: next_s.rdata = u0.rx_byte;
				ADDR_PORT1_DATA: next_s.rdata = u1.rx_byte;
				ADDR_PORT0_CTL: next_s.rdata = {s.pwr0[BIT_VIEW] ? s.fe0 : s.ctl0[7], s.ctl0[6:0]};
				ADDR_PORT1_CTL: next_s.rdata = {s.t3c[BIT_VIEW] ? s.fe1 : s.ctl1[7], s.ctl1[6:0]};
				ADDR_PORT0_POWER: next_s.rdata = s.pwr0;
				ADDR_AUX_ONE: next_s.rdata = s.aux;
				ADDR_TIMER3_CTL: next_s.rdata = s.t3c;
				ADDR_IRQ_STATUS: next_s.rdata = {4'h0, s.irq_st};
				ADDR_IRQ_MASK: next_s.rdata = {4'h0, s.irq_mask};
				default: next_s.rdata = RST_BYTE;
			endcase
		end

		// swap acts at once; changing it mid-transfer corrupts the frame
		if (swap) begin
			next_s.p03_out = u0.data_out;
			next_s.p03_oe_n = !u0.data_drive;
			next_s.p20_out = u0.line_out;
			next_s.p20_oe_n = 1'h0;
		end else begin
			next_s.p20_out = u0.data_out;
			next_s.p20_oe_n = !u0.data_drive;
			next_s.p03_out = u0.line_out;
			next_s.p03_oe_n = 1'h0;
		end
		next_s.rxd1_out = u1.data_out;
		next_s.rxd1_oe_n = !u1.data_drive;
		next_s.txd1_out = u1.line_out;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '{meta: 3'h7, sync: 3'h7, p20_out: 1'h1, p20_oe_n: 1'h1, p03_out: 1'h1,
				rxd1_out: 1'h1, rxd1_oe_n: 1'h1, txd1_out: 1'h1, default: '0};
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign rdata = s.rdata;
	assign pin_p20_out = s.p20_out;
	assign pin_p20_oe_n = s.p20_oe_n;
	assign pin_p03_out = s.p03_out;
	assign pin_p03_oe_n = s.p03_oe_n;
	assign rxd1_out = s.rxd1_out;
	assign rxd1_oe_n = s.rxd1_oe_n;
	assign txd1_out = s.txd1_out;
	assign irq = s.irq;
endmodule
`default_nettype wire

//--- rtl/dsp_pkg.sv
/*
 Constants, types and field layout shared by the dual serial port core.
 Assumes a byte-wide register port and a single 200 MHz system clock.
*/
package dsp_pkg;
	localparam int          CLK_MHZ          = 200;
	localparam logic [7:0]  ADDR_PORT0_POWER = 8'h87;
	localparam logic [7:0]  ADDR_PORT0_CTL   = 8'h98;
	localparam logic [7:0]  ADDR_PORT0_DATA  = 8'h99;
	localparam logic [7:0]  ADDR_PORT1_DATA  = 8'h9a;
	localparam logic [7:0]  ADDR_PORT1_CTL   = 8'h9b;
	localparam logic [7:0]  ADDR_AUX_ONE     = 8'ha2;
	localparam logic [7:0]  ADDR_TIMER3_CTL  = 8'hc4;
	localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'he8;
	localparam logic [7:0]  ADDR_IRQ_MASK    = 8'he9;
	localparam logic [7:0]  RST_BYTE         = 8'h00;
	localparam logic [7:0]  AUX_RO_MASK      = 8'hfd;
	localparam int          BIT_DOUBLE       = 7;
	localparam int          BIT_VIEW         = 6;
	localparam int          BIT_BAUD_SEL     = 5;
	localparam int          BIT_PIN_SWAP     = 2;
	localparam int          CTL_MODE_HI      = 7;
	localparam int          CTL_SM2          = 5;
	localparam int          CTL_REN          = 4;
	localparam int          CTL_TB8          = 3;
	localparam int          CTL_TI           = 1;
	localparam int          CTL_RI           = 0;
	localparam int          IRQ_TI0          = 0;
	localparam int          IRQ_RI0          = 1;
	localparam int          IRQ_TI1          = 2;
	localparam int          IRQ_RI1          = 3;
	// divisors are half bit periods: two half ticks make one bit
	localparam logic [5:0]  HALF_M0_SLOW     = 6'h06;
	localparam logic [5:0]  HALF_M0_FAST     = 6'h01;
	localparam logic [5:0]  HALF_M2_SLOW     = 6'h20;
	localparam logic [5:0]  HALF_M2_FAST     = 6'h10;
	localparam logic [5:0]  HALF_OVF_P0      = 6'h10;
	localparam logic [5:0]  HALF_OVF_P0_DBL  = 6'h08;
	localparam logic [5:0]  HALF_OVF_P1      = 6'h08;
	localparam logic [3:0]  FRAME_SYNC       = 4'h8;
	localparam logic [3:0]  FRAME_SHORT      = 4'ha;
	localparam logic [3:0]  FRAME_LONG       = 4'hb;

	typedef enum logic [1:0] {
		MODE_SYNC   = 2'h0,
		MODE_ASYNC1 = 2'h1,
		MODE_ASYNC2 = 2'h2,
		MODE_ASYNC3 = 2'h3
	} dsp_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_TX   = 3'h2,
		ST_RX   = 3'h4
	} dsp_state_t;
endpackage

//--- rtl/dsp_port_if.sv
/*
 Bundle between the register side of the core and one port engine.
 Assumes both ends run on the same system clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface dsp_port_if;
	import dsp_pkg::*;
	dsp_mode_t  mode;
	logic       sm2;
	logic       ren;
	logic       ri_flag;
	logic       tb8;
	logic       half_tick;
	logic       start_tx;
	logic [7:0] tx_byte;
	logic       data_in;
	logic [7:0] rx_byte;
	logic       data_out;
	logic       data_drive;
	logic       line_out;
	logic       set_ti;
	logic       set_ri;
	logic       busy;
	modport ctl (output mode, sm2, ren, ri_flag, tb8, half_tick, start_tx, tx_byte, data_in,
		input rx_byte, data_out, data_drive, line_out, set_ti, set_ri, busy);
	modport eng (input mode, sm2, ren, ri_flag, tb8, half_tick, start_tx, tx_byte, data_in,
		output rx_byte, data_out, data_drive, line_out, set_ti, set_ri, busy);
endinterface
`default_nettype wire

//--- rtl/dsp_baud.sv
/*
 Half-bit tick divider: counts enabled cycles, pulses every half_div of them.
 Assumes inc is a same-clock pulse or level and half_div is nonzero.
*/
`timescale 1ns/100ps
`default_nettype none
module dsp_baud
	import dsp_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       clr,
	input  wire logic       inc,
	input  wire logic [5:0] half_div,
	output logic            tick
);
	typedef struct packed {
		logic [5:0] cnt;
		logic       tick;
	} dsp_baud_t;

	dsp_baud_t s;
	dsp_baud_t next_s;

	always_comb begin
		next_s = s;
		next_s.tick = 1'h0;
		if (clr) begin
			next_s.cnt = 6'h00;
		end else if (inc) begin
			if (s.cnt >= half_div - 6'h01) begin
				next_s.cnt = 6'h00;
				next_s.tick = 1'h1;
			end else begin
				next_s.cnt = s.cnt + 6'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule
`default_nettype wire

//--- rtl/dsp_port.sv
/*
 One serial port engine: mode 0 shift register both ways, framed send otherwise.
 Assumes half_tick comes from a divider cleared while the engine is idle.
*/
`timescale 1ns/100ps
`default_nettype none
module dsp_port
	import dsp_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	dsp_port_if.eng   p
);
	typedef struct packed {
		dsp_state_t  state;
		logic        phase;
		logic [3:0]  cnt;
		logic [10:0] sr;
		logic [7:0]  rx_byte;
		logic        data_out;
		logic        data_drive;
		logic        line_out;
		logic        set_ti;
		logic        set_ri;
	} dsp_port_t;

	dsp_port_t s;
	dsp_port_t next_s;
	logic [3:0] frame_len;
	logic       sync_mode;

	assign sync_mode = (p.mode == MODE_SYNC);

	always_comb begin
		case (p.mode)
			MODE_SYNC:   frame_len = FRAME_SYNC;
			MODE_ASYNC1: frame_len = FRAME_SHORT;
			default:     frame_len = FRAME_LONG;
		endcase
	end

	always_comb begin
		next_s = s;
		next_s.set_ti = 1'h0;
		next_s.set_ri = 1'h0;
		case (s.state)
			ST_IDLE: begin
				next_s.line_out = 1'h1;
				next_s.data_drive = 1'h0;
				next_s.phase = 1'h0;
				next_s.cnt = 4'h0;
				if (p.start_tx) begin
					next_s.state = ST_TX;
					if (sync_mode) begin
						next_s.sr = {3'h7, p.tx_byte};
						next_s.data_out = p.tx_byte[0];
						next_s.data_drive = 1'h1;
					end else begin
						next_s.sr = (p.mode == MODE_ASYNC1) ? {2'h3, p.tx_byte, 1'h0}
							: {1'h1, p.tb8, p.tx_byte, 1'h0};
						next_s.line_out = 1'h0;
					end
				end else if (sync_mode && p.ren && !p.ri_flag && !s.set_ri) begin
					// done flag reaches the register a cycle late; no restart on the done pulse
					next_s.state = ST_RX;
				end
			end
			ST_TX: begin
				if (p.half_tick) begin
					if (!s.phase) begin
						next_s.phase = 1'h1;
						if (sync_mode) begin
							next_s.line_out = 1'h0;
						end
					end else begin
						next_s.phase = 1'h0;
						next_s.cnt = s.cnt + 4'h1;
						next_s.sr = {1'h1, s.sr[10:1]};
						next_s.line_out = sync_mode ? 1'h1 : s.sr[1];
						next_s.data_out = s.sr[1];
						if (s.cnt + 4'h1 == frame_len) begin
							next_s.state = ST_IDLE;
							next_s.set_ti = 1'h1;
							next_s.data_drive = 1'h0;
							next_s.line_out = 1'h1;
						end
					end
				end
			end
			ST_RX: begin
				if (!p.ren) begin
					next_s.state = ST_IDLE;
				end else if (p.half_tick) begin
					if (!s.phase) begin
						next_s.phase = 1'h1;
						next_s.line_out = 1'h0;
					end else begin
						// sample on the rising clock edge, first bit lands lowest
						next_s.phase = 1'h0;
						next_s.line_out = 1'h1;
						next_s.cnt = s.cnt + 4'h1;
						next_s.sr = {3'h0, p.data_in, s.sr[7:1]};
						if (s.cnt + 4'h1 == FRAME_SYNC) begin
							next_s.state = ST_IDLE;
							next_s.rx_byte = {p.data_in, s.sr[7:1]};
							next_s.set_ri = 1'h1;
						end
					end
				end
			end
			default: begin
				next_s.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '{state: ST_IDLE, line_out: 1'h1, data_out: 1'h1, default: '0};
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign p.rx_byte = s.rx_byte;
	assign p.data_out = s.data_out;
	assign p.data_drive = s.data_drive;
	assign p.line_out = s.line_out;
	assign p.set_ti = s.set_ti;
	assign p.set_ri = s.set_ri;
	assign p.busy = (s.state != ST_IDLE);
endmodule
`default_nettype wire

//--- testbench/dsp_monitor.sv
/*
 Checker on the dual serial port core's top ports.
 Assumes software never swaps pins during a transfer.
*/
`timescale 1ns/100ps
`default_nettype none
module dsp_monitor
	import dsp_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       pin_p20_oe_n,
	input wire logic       pin_p03_out,
	input wire logic       irq
);
	logic [7:0] ctl0;
	logic       swap;
	logic       m0clk;
	// shadow copies: mode and pin mapping are not visible at the ports
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctl0 <= 8'h00;
			swap <= 1'b0;
		end else if (wr && addr == ADDR_PORT0_CTL) begin
			ctl0 <= wdata;
		end else if (wr && addr == ADDR_AUX_ONE) begin
			swap <= wdata[BIT_PIN_SWAP];
		end
	end
	assign m0clk = !swap && ctl0[7:6] == 2'b00;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_wr_t3;
		wr && addr == ADDR_TIMER3_CTL;
	endsequence
	sequence s_rd_t3;
		rd && addr == ADDR_TIMER3_CTL;
	endsequence
	sequence s_low_h6;
		!pin_p03_out [*6] ##1 pin_p03_out;
	endsequence
	property p_rdata_idle;
		!rd |=> rdata == 8'h00;
	endproperty
	property p_unmapped;
		rd && addr == 8'h00 |=> rdata == 8'h00;
	endproperty
	property p_aux_bit1;
		rd && addr == ADDR_AUX_ONE |=> !rdata[1];
	endproperty
	property p_t3_back;
		s_wr_t3 ##1 s_rd_t3 |=> rdata == $past(wdata, 2);
	endproperty
	property p_mask_off;
		wr && addr == ADDR_IRQ_MASK && wdata == 8'h00 |-> ##2 !irq;
	endproperty
	property p_swap;
		wr && addr == ADDR_AUX_ONE && wdata[BIT_PIN_SWAP] |-> ##2 !pin_p20_oe_n;
	endproperty
	property p_clk_fast;
		m0clk && ctl0[CTL_SM2] && $fell(pin_p03_out) |=> pin_p03_out;
	endproperty
	property p_clk_slow;
		m0clk && !ctl0[CTL_SM2] && $fell(pin_p03_out) |-> s_low_h6;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle");
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	a_aux_bit1: assert property (p_aux_bit1) else $error("aux bit 1 not zero");
	a_t3_back: assert property (p_t3_back) else $error("timer3 ctl readback");
	a_mask_off: assert property (p_mask_off) else $error("irq while masked");
	a_swap: assert property (p_swap) else $error("swap not immediate");
	a_clk_fast: assert property (p_clk_fast) else $error("fast shift clock");
	a_clk_slow: assert property (p_clk_slow) else $error("slow shift clock");
endmodule
bind dsp_top dsp_monitor dsp_monitor_i (.clk(clk), .rst_n(rst_n), .addr(addr),
	.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pin_p20_oe_n(pin_p20_oe_n),
	.pin_p03_out(pin_p03_out), .irq(irq));
`default_nettype wire

//--- testbench/dsp_slave.sv
/*
 Mode 0 slave shift register clocked by the core's shift clock.
 Assumes the bench resolves the shared data line.
*/
`timescale 1ns/100ps
`default_nettype none
module dsp_slave (
	input  wire logic       sclk,
	input  wire logic       line,
	input  wire logic       load,
	input  wire logic [7:0] send,
	output logic            drive,
	output logic [7:0]      got
);
	logic [3:0] idx = 4'h8;
	// sample mid-bit on the falling clock, lsb first
	always @(negedge sclk) got <= {line, got[7:1]};
	// next bit only after the master's rising clock
	always @(posedge sclk or posedge load) begin
		if (load) idx <= 4'h0;
		else if (!idx[3]) idx <= idx + 4'h1;
	end
	// spent frame shows the inverse, never a stale bit
	assign drive = idx[3] ? ~send[7] : send[idx[2:0]];
endmodule
`default_nettype wire

//--- testbench/dsp_top_tb.sv
/*
 Self-checking bench for the dual serial port core.
 Assumes the slave model on port 0 and pull-ups on idle lines.
*/
`timescale 1ns/100ps
`default_nettype none
module dsp_top_tb;
	import dsp_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic       load = 1'b0;
	logic       t3_ovf = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] sbyte = 8'h00;
	logic [7:0] rdata, got;
	logic       p20_out, p20_oe_n, p03_out, p03_oe_n, r1_out, r1_oe_n, txd1, irq, sdrv;
	wire logic  p20 = p20_oe_n ? sdrv : p20_out;
	wire logic  p03 = p03_oe_n ? 1'b1 : p03_out;
	wire logic  r1 = r1_oe_n ? 1'b1 : r1_out;
	int         fail_count = 0;
	int         num_checks = 0;
	always #2.5 clk = ~clk;
	dsp_top dsp_top_i (.clk(clk), .rst_n(rst_n), .ce(1'b1), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .t1_ovf(1'b0), .t3_ovf(t3_ovf),
		.pin_p20_in(p20), .pin_p20_out(p20_out), .pin_p20_oe_n(p20_oe_n),
		.pin_p03_in(p03), .pin_p03_out(p03_out), .pin_p03_oe_n(p03_oe_n),
		.rxd1_in(r1), .rxd1_out(r1_out), .rxd1_oe_n(r1_oe_n), .txd1_out(txd1), .irq(irq));
	dsp_slave dsp_slave_i (.sclk(p03), .line(p20), .load(load), .send(sbyte),
		.drive(sdrv), .got(got));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		cyc(1'b1, 1'b0, a, d);
		cyc(1'b0, 1'b0, a, d);
	endtask
	task automatic rreg(input logic [7:0] a, output logic [7:0] v);
		cyc(1'b0, 1'b1, a, 8'h00);
		cyc(1'b0, 1'b0, a, 8'h00);
		#1 v = rdata;
	endtask
	task automatic wait_st(input int b);
		logic [7:0] v;
		v = 8'h00;
		for (int i = 0; i < 600 && !v[b]; i++) rreg(ADDR_IRQ_STATUS, v);
		check({7'h0, v[b]}, 8'h01);
	endtask
	task automatic reload(input logic [7:0] b);
		sbyte <= b;
		load <= 1'b1;
		#1 load <= 1'b0;
	endtask
	task automatic t_regs;
		logic [7:0] v;
		rreg(ADDR_TIMER3_CTL, v);
		check(v, 8'h00);
		check({5'h0, r1_out, r1_oe_n, txd1}, 8'h07);
		rreg(ADDR_PORT0_DATA, v);
		check(v, 8'h00);
		cyc(1'b1, 1'b0, ADDR_TIMER3_CTL, 8'he0);
		rreg(ADDR_TIMER3_CTL, v);
		check(v, 8'he0);
		wreg(ADDR_PORT1_CTL, 8'h80);
		rreg(ADDR_PORT1_CTL, v);
		check(v, 8'h80);
		wreg(ADDR_TIMER3_CTL, 8'h00);
		rreg(ADDR_PORT1_CTL, v);
		check(v, 8'h00);
		rreg(8'h00, v);
		check(v, 8'h00);
		wreg(ADDR_AUX_ONE, 8'hff);
		rreg(ADDR_AUX_ONE, v);
		check(v, AUX_RO_MASK);
		check({6'h0, p20_oe_n, p03_oe_n}, 8'h01);
		wreg(ADDR_AUX_ONE, 8'h00);
		$display("test regs done");
	endtask
	task automatic t_tx(input logic sm2, input logic [7:0] b);
		logic [7:0] v;
		wreg(ADDR_PORT0_CTL, {2'b00, sm2, 5'h00});
		wreg(ADDR_IRQ_MASK, 8'h00);
		reload(8'h00);
		wreg(ADDR_PORT0_DATA, b);
		// second write lands while busy and must be ignored
		wreg(ADDR_PORT0_DATA, ~b);
		wait_st(IRQ_TI0);
		check(got, b);
		rreg(ADDR_IRQ_STATUS, v);
		check(v & 8'h01, 8'h01);
		check({7'h0, irq}, 8'h00);
		wreg(ADDR_IRQ_MASK, 8'h01);
		@(posedge clk);
		#1 check({7'h0, irq}, 8'h01);
		wreg(ADDR_IRQ_STATUS, 8'h01);
		@(posedge clk);
		#1 check({7'h0, irq}, 8'h00);
		$display("test tx done");
	endtask
	task automatic t_rx;
		logic [7:0] v;
		reload(8'h96);
		wreg(ADDR_IRQ_STATUS, 8'hff);
		wreg(ADDR_PORT0_CTL, 8'h10);
		wait_st(IRQ_RI0);
		wreg(ADDR_PORT0_CTL, 8'h00);
		rreg(ADDR_PORT0_DATA, v);
		check(v, 8'h96);
		$display("test rx done");
	endtask
	// start bit length in cycles on the port's transmit line
	task automatic t_rate(input logic p0, input logic [7:0] t3, input logic [7:0] pwr,
		input logic [7:0] ctl, input int w);
		int n;
		wreg(ADDR_TIMER3_CTL, t3);
		wreg(ADDR_PORT0_POWER, pwr);
		wreg(p0 ? ADDR_PORT0_CTL : ADDR_PORT1_CTL, ctl);
		wreg(p0 ? ADDR_PORT0_DATA : ADDR_PORT1_DATA, 8'hff);
		n = 0;
		while ((p0 ? p03_out : txd1) === 1'b1 && n < 100) begin
			@(posedge clk);
			#1 n++;
		end
		n = 0;
		while ((p0 ? p03_out : txd1) === 1'b0 && n < 200) begin
			@(posedge clk);
			#1 n++;
		end
		check(n[7:0], w[7:0]);
		wait_st(p0 ? IRQ_TI0 : IRQ_TI1);
		wreg(p0 ? ADDR_PORT0_CTL : ADDR_PORT1_CTL, 8'h00);
		wreg(ADDR_IRQ_STATUS, 8'hff);
		$display("test rate done");
	endtask
	task automatic print_verdict;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_tx(1'b1, 8'ha5);
		t_tx(1'b0, 8'h3c);
		t_rx;
		t_rate(1'b0, 8'h80, 8'h00, 8'h80, 32);
		t_rate(1'b0, 8'h00, 8'h00, 8'h80, 64);
		t_rate(1'b1, 8'h00, 8'h80, 8'h80, 32);
		// overflow on every cycle; timer 1 stays silent so a wrong source stalls
		t3_ovf <= 1'b1;
		t_rate(1'b0, 8'h80, 8'h00, 8'h40, 16);
		t_rate(1'b1, 8'h20, 8'h00, 8'h40, 32);
		t_rate(1'b1, 8'h20, 8'h80, 8'h40, 16);
		print_verdict;
	end
	// runs take a few thousand cycles; this leaves ample margin
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		print_verdict;
	end
endmodule
`default_nettype wire
